// ===== src/scg_pkg.sv
// constants, field layouts and types for the signed gated counter block
package scg_pkg;

    // counter value width and count of counters
    localparam int unsigned CNT_W = 32;
    localparam int unsigned NUM_CNT = 4;
    localparam int unsigned HARDWARE_GATE_INPUT_CNT = 3;

    // full signed range limits
    localparam logic [31:0] LIM_MAX = 32'h7fff_ffff;
    localparam logic [31:0] LIM_MIN = 32'h8000_0000;
    localparam logic [31:0] ONE = 32'h0000_0001;

    // address layout: counter index in [6:5], register index in [4:2]
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned CNT_SEL_LSB = 5;
    localparam int unsigned REG_SEL_LSB = 2;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_LOAD = 3'h1;
    localparam logic [2:0] REG_END = 3'h2;
    localparam logic [2:0] REG_VALUE = 3'h3;
    localparam logic [2:0] REG_STATUS = 3'h4;

    // status register bits
    localparam int unsigned ST_OVF = 0;
    localparam int unsigned ST_UNF = 1;
    localparam int unsigned ST_RUN = 2;
    localparam int unsigned ST_CLOSED = 3;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // operating modes
    typedef enum logic [1:0] {
        MODE_CONT,
        MODE_ONCE,
        MODE_PERIODIC,
        MODE_RSVD
    } scg_mode_t;

    // preferred counting direction
    typedef enum logic [1:0] {
        DIR_NONE,
        DIR_UP,
        DIR_DOWN,
        DIR_RSVD
    } scg_dir_t;

    // control register layout (low bits of the word)
    typedef struct packed {
        logic unf_evt_en;    // bit 8: underflow event output enable
        logic ovf_evt_en;    // bit 7: overflow event output enable
        logic hardware_gate_input_en;    // bit 6: hardware gate evaluation (counter 3)
        logic gate_abort;    // bit 5: 1 abort, 0 interrupt gate function
        logic software_gate_bit;       // bit 4: software gate bit
        scg_dir_t dir;       // bits 3:2
        scg_mode_t mode;     // bits 1:0
    } scg_ctrl_t;

    localparam int unsigned CTRL_W = $bits(scg_ctrl_t);
    localparam logic [8:0] CTRL_RST = 9'h000;

    // one counter's count pulse pair
    typedef struct packed {
        logic up;
        logic dn;
    } scg_pulse_t;

endpackage

// ===== src/scg_counter_top.sv
// four signed 32-bit gated event counters with an axi4-lite register slave
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module scg_counter_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic [scg_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [scg_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // count pulses, one cycle each, per counter
    input wire scg_pkg::scg_pulse_t [scg_pkg::NUM_CNT-1:0] count_pulse,
    // hardware gate input of counter three
    input wire logic hardware_gate_input,
    // per-counter overflow / underflow event pulses
    output logic [scg_pkg::NUM_CNT-1:0] overflow_evt_q,
    output logic [scg_pkg::NUM_CNT-1:0] underflow_evt_q
);

    // byte-lane merge for register writes
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // register index of an address
    function automatic logic [2:0] reg_sel(
            input logic [scg_pkg::ADDR_W-1:0] a);
        return a[scg_pkg::REG_SEL_LSB +: 3];
    endfunction

    // counter index of an address
    function automatic logic [1:0] cnt_sel(
            input logic [scg_pkg::ADDR_W-1:0] a);
        return a[scg_pkg::CNT_SEL_LSB +: 2];
    endfunction

    // true when the address names an existing register
    function automatic logic addr_ok(input logic [scg_pkg::ADDR_W-1:0] a);
        return reg_sel(a) <= scg_pkg::REG_STATUS;
    endfunction

    // write transaction taken this cycle
    logic wr_fire;
    // write address and data as presented on the bus, not registered
    logic [scg_pkg::ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    // per-counter state visible to the read mux
    logic [scg_pkg::NUM_CNT-1:0][scg_pkg::CTRL_W-1:0] ctrl_q;
    logic [scg_pkg::NUM_CNT-1:0][31:0] load_q;
    logic [scg_pkg::NUM_CNT-1:0][31:0] end_q;
    logic [scg_pkg::NUM_CNT-1:0][31:0] value_q;
    logic [scg_pkg::NUM_CNT-1:0] ovf_q;
    logic [scg_pkg::NUM_CNT-1:0] unf_q;
    logic [scg_pkg::NUM_CNT-1:0] closed_q;
    logic [scg_pkg::NUM_CNT-1:0] gate_lvl;

    // both write channels present and no response pending
    // a second write waits until the response has been taken
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
                     !s_axi_awready;
    assign wr_addr = s_axi_awaddr;
    assign wr_data = s_axi_wdata;
    assign wr_strb = s_axi_wstrb;

    // write handshake: accept address and data together, one cycle ready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= wr_fire;
            s_axi_wready <= wr_fire;
        end
    end

    // write response follows the accepted pair
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= scg_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_ok(wr_addr) ? scg_pkg::RESP_OKAY
                                            : scg_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read mux of the addressed register
    logic [31:0] rd_mux;
    always_comb begin
        logic [1:0] c;
        c = cnt_sel(s_axi_araddr);
        rd_mux = 32'h0000_0000;
        case (reg_sel(s_axi_araddr))
            scg_pkg::REG_CTRL: rd_mux[scg_pkg::CTRL_W-1:0] = ctrl_q[c];
            scg_pkg::REG_LOAD: rd_mux = load_q[c];
            scg_pkg::REG_END: rd_mux = end_q[c];
            scg_pkg::REG_VALUE: rd_mux = value_q[c];
            scg_pkg::REG_STATUS: begin
                rd_mux[scg_pkg::ST_OVF] = ovf_q[c];
                rd_mux[scg_pkg::ST_UNF] = unf_q[c];
                rd_mux[scg_pkg::ST_RUN] = gate_lvl[c] && !closed_q[c];
                rd_mux[scg_pkg::ST_CLOSED] = closed_q[c];
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read channel: address taken when no data pending, data next cycle
    // rdata holds until rready is seen
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= scg_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= addr_ok(s_axi_araddr) ? scg_pkg::RESP_OKAY
                                                 : scg_pkg::RESP_SLVERR;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // one counter per generate step
    for (genvar i = 0; i < scg_pkg::NUM_CNT; i++) begin : g_cnt
        // decoded control fields
        scg_pkg::scg_ctrl_t ctl;
        // gate request level and its previous value
        logic gate_req;
        logic gate_prev_q;
        logic gate_rise;
        logic run;
        // writes aimed at this counter
        logic wr_me;
        logic wr_ctrl;
        logic wr_load;
        logic wr_clr;
        // limit detection for this pulse
        logic hit_up;
        logic hit_dn;
        logic [31:0] up_to;
        logic [31:0] dn_to;
        // control word after a byte-lane merge
        logic [31:0] ctrl_merged;

        assign ctl = scg_pkg::scg_ctrl_t'(ctrl_q[i]);
        assign wr_me = wr_fire && (cnt_sel(wr_addr) == 2'(i));
        assign wr_ctrl = wr_me && (reg_sel(wr_addr) == scg_pkg::REG_CTRL);
        assign wr_load = wr_me && (reg_sel(wr_addr) == scg_pkg::REG_LOAD);
        // status clear request: write ones to the overflow and underflow bits
        assign wr_clr = wr_me && (reg_sel(wr_addr) == scg_pkg::REG_STATUS);
        assign ctrl_merged = merge_bytes({23'h0, ctrl_q[i]}, wr_data, wr_strb);

        // gate request: software only, or combined with hardware input
        if (i == scg_pkg::HARDWARE_GATE_INPUT_CNT) begin : g_hw
            assign gate_req = ctl.hardware_gate_input_en ?
                (ctl.software_gate_bit && hardware_gate_input) :
                ctl.software_gate_bit;
        end else begin : g_sw
            assign gate_req = ctl.software_gate_bit;
        end
        assign gate_lvl[i] = gate_req;
        // rising edge of the (internal) gate reopens the counter
        assign gate_rise = gate_req && !gate_prev_q;
        assign run = gate_req && !closed_q[i];

        // limit reached in up and in down direction, per direction setting
        always_comb begin
            case (ctl.dir)
                scg_pkg::DIR_NONE: hit_up = value_q[i] == scg_pkg::LIM_MAX;
                scg_pkg::DIR_UP:
                    hit_up = value_q[i] == end_q[i] - scg_pkg::ONE;
                default: hit_up = 1'b0;
            endcase
            case (ctl.dir)
                scg_pkg::DIR_NONE: hit_dn = value_q[i] == scg_pkg::LIM_MIN;
                scg_pkg::DIR_DOWN:
                    hit_dn = value_q[i] == end_q[i] + scg_pkg::ONE;
                default: hit_dn = 1'b0;
            endcase
        end

        // value taken on a limit hit
        // directed and periodic modes reload, the others wrap
        always_comb begin
            if (ctl.dir == scg_pkg::DIR_NONE &&
                ctl.mode != scg_pkg::MODE_PERIODIC) begin
                up_to = scg_pkg::LIM_MIN;
                dn_to = scg_pkg::LIM_MAX;
            end else begin
                up_to = load_q[i];
                dn_to = load_q[i];
            end
        end

        // configuration registers
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ctrl_q[i] <= scg_pkg::CTRL_RST;
                load_q[i] <= 32'h0000_0000;
                end_q[i] <= scg_pkg::LIM_MAX;
            end else if (wr_me) begin
                if (wr_ctrl) begin
                    ctrl_q[i] <= ctrl_merged[scg_pkg::CTRL_W-1:0];
                end
                if (wr_load) begin
                    load_q[i] <= merge_bytes(load_q[i], wr_data, wr_strb);
                end
                if (reg_sel(wr_addr) == scg_pkg::REG_END) begin
                    end_q[i] <= merge_bytes(end_q[i], wr_data, wr_strb);
                end
            end
        end

        // gate edge history
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                gate_prev_q <= 1'b0;
            end else begin
                gate_prev_q <= gate_req;
            end
        end

        // counter value
        // order: load while the gate request is low, then gate rise, then pulses
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                value_q[i] <= 32'h0000_0000;
            end else if (wr_load && !gate_req) begin
                // a new load value is the start point while the gate request is low
                value_q[i] <= merge_bytes(load_q[i], wr_data,
                                          wr_strb);
            end else if (gate_rise) begin
                if (ctl.gate_abort ||
                    (ctl.mode == scg_pkg::MODE_ONCE &&
                     ctl.dir != scg_pkg::DIR_NONE && closed_q[i])) begin
                    value_q[i] <= load_q[i];
                end
                // interrupt function keeps the present value, except a closed directed single shot reloads
            end else if (run && count_pulse[i].up && !count_pulse[i].dn) begin
                value_q[i] <= hit_up ? up_to : value_q[i] + scg_pkg::ONE;
            end else if (run && count_pulse[i].dn && !count_pulse[i].up) begin
                value_q[i] <= hit_dn ? dn_to : value_q[i] - scg_pkg::ONE;
            end
        end

        // automatic gate close in single-shot mode, reopen on gate rise
        // a pulse in the gate-rise cycle is dropped
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                closed_q[i] <= 1'b0;
            end else if (gate_rise) begin
                closed_q[i] <= 1'b0;
            end else if (run && ctl.mode == scg_pkg::MODE_ONCE &&
                         ((count_pulse[i].up && !count_pulse[i].dn &&
                           hit_up) ||
                          (count_pulse[i].dn && !count_pulse[i].up &&
                           hit_dn))) begin
                closed_q[i] <= 1'b1;
            end
        end

        // sticky flags: a new event wins over a clear in the same cycle
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ovf_q[i] <= 1'b0;
                unf_q[i] <= 1'b0;
            end else begin
                if (run && !gate_rise && count_pulse[i].up &&
                    !count_pulse[i].dn && hit_up) begin
                    ovf_q[i] <= 1'b1;
                end else if (wr_clr && wr_strb[0] &&
                             wr_data[scg_pkg::ST_OVF]) begin
                    ovf_q[i] <= 1'b0;
                end
                if (run && !gate_rise && count_pulse[i].dn &&
                    !count_pulse[i].up && hit_dn) begin
                    unf_q[i] <= 1'b1;
                end else if (wr_clr && wr_strb[0] &&
                             wr_data[scg_pkg::ST_UNF]) begin
                    unf_q[i] <= 1'b0;
                end
            end
        end

        // enabled event pulses for an outside interrupt controller
        // one cycle per event; the flags keep the sticky copy
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                overflow_evt_q[i] <= 1'b0;
                underflow_evt_q[i] <= 1'b0;
            end else begin
                overflow_evt_q[i] <= ctl.ovf_evt_en && run && !gate_rise &&
                    count_pulse[i].up && !count_pulse[i].dn && hit_up;
                underflow_evt_q[i] <= ctl.unf_evt_en && run && !gate_rise &&
                    count_pulse[i].dn && !count_pulse[i].up && hit_dn;
            end
        end
    end

endmodule // scg_counter_top

// ===== tb/scg_checker.sv
// concurrent checks on the counter top ports
`timescale 1ns/1ps
module scg_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write side of the register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read side of the register bus
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pulses in, events out
    input wire scg_pkg::scg_pulse_t [scg_pkg::NUM_CNT-1:0] count_pulse,
    input wire logic [scg_pkg::NUM_CNT-1:0] overflow_evt_q,
    input wire logic [scg_pkg::NUM_CNT-1:0] underflow_evt_q
);
    // one clock domain for every check
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // write accepted, then answered
    sequence seq_wr_take;
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    endsequence
    sequence seq_wr_answer;
        s_axi_awready && s_axi_wready && s_axi_bvalid;
    endsequence
    // read accepted, then answered
    sequence seq_rd_take;
        s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    endsequence
    sequence seq_rd_answer;
        s_axi_arready && s_axi_rvalid;
    endsequence

    chk_wr_answer: assert property (seq_wr_take |=> seq_wr_answer)
        else $error("write not answered one cycle after acceptance");
    chk_aw_w_pair: assert property (s_axi_awready == s_axi_wready)
        else $error("address and data ready differ");
    chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("address ready held past one cycle");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed before taken");
    chk_b_release: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid)
        else $error("write response kept after it was taken");
    chk_rd_answer: assert property (seq_rd_take |=> seq_rd_answer)
        else $error("read not answered one cycle after acceptance");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed before taken");

    // each event needs a lone pulse of its own side one edge earlier
    for (genvar i = 0; i < scg_pkg::NUM_CNT; i++) begin : g_cnt
        chk_ovf_cause: assert property (
            overflow_evt_q[i] |-> $past(count_pulse[i]) == 2'b10)
            else $error("overflow event without an up pulse");
        chk_unf_cause: assert property (
            underflow_evt_q[i] |-> $past(count_pulse[i]) == 2'b01)
            else $error("underflow event without a down pulse");
        chk_evt_excl: assert property (
            !(overflow_evt_q[i] && underflow_evt_q[i]))
            else $error("overflow and underflow events together");
    end
endmodule // scg_checker

bind scg_counter_top scg_checker u_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .count_pulse, .overflow_evt_q, .underflow_evt_q
);

// ===== tb/scg_pulse_src.sv
// count pulse and hardware gate source standing in for the encoder side
`timescale 1ns/1ps
module scg_pulse_src (
    // clock
    input logic aclk,
    // pulses and gate level toward the counters
    output scg_pkg::scg_pulse_t [scg_pkg::NUM_CNT-1:0] count_pulse,
    output logic hardware_gate_input
);
    // idle: no pulse, gate low
    initial begin
        count_pulse = '0;
        hardware_gate_input = 1'b0;
    end

    // n one-cycle pulses on one counter, idle edges around them
    task automatic send(input int idx, input logic up, input int n);
        repeat (2) @(posedge aclk);
        for (int k = 0; k < n; k++) begin
            count_pulse[idx] <= up ? 2'b10 : 2'b01;
            @(posedge aclk);
        end
        count_pulse[idx] <= 2'b00;
        repeat (2) @(posedge aclk);
    endtask

    // gate level change, then let the edge detector settle
    task automatic set_gate(input logic v);
        @(posedge aclk);
        hardware_gate_input <= v;
        repeat (2) @(posedge aclk);
    endtask
endmodule // scg_pulse_src

// ===== tb/signed_counter_modes_gate_bench.sv
// self-checking bench for the signed gated counter block
`timescale 1ns/1ps
module signed_counter_modes_gate_bench;
    // clock, reset and register bus
    logic aclk, aresetn;
    logic [scg_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, hardware_gate_input;
    // pulses and events
    scg_pkg::scg_pulse_t [scg_pkg::NUM_CNT-1:0] count_pulse;
    logic [scg_pkg::NUM_CNT-1:0] overflow_evt_q, underflow_evt_q;
    // tallies
    int fails = 0;
    int comparisons = 0;
    int ovf_seen = 0;
    int unf_seen = 0;
    // directed cases: mode/dir, load, end, side, pulses, value, closed, next
    logic [3:0] tc [6] = '{4'h5, 4'h9, 4'h6, 4'ha, 4'h2, 4'h5};
    logic [31:0] tl [6] = '{32'h5, 32'hffff_fffb, 32'h5, 32'hffff_fffb,
        32'h7fff_fffe, 32'h8000_0000};
    logic [31:0] te [6] = '{32'h8, 32'hffff_fff8, 32'h8, 32'hffff_fff8,
        32'h7fff_ffff, 32'h8};
    logic tu [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    int tn [6] = '{3, 3, 4, 4, 2, 1};
    logic [31:0] tx [6] = '{32'h5, 32'hffff_fffb, 32'h6, 32'hffff_fffa,
        32'h7fff_fffe, 32'h7fff_ffff};
    logic tz [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    logic [31:0] ty [6] = '{32'h6, 32'hffff_fffa, 32'h0, 32'h0, 32'h0, 32'h0};

    scg_counter_top dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .count_pulse, .hardware_gate_input,
        .overflow_evt_q, .underflow_evt_q
    );
    scg_pulse_src src (.aclk, .count_pulse, .hardware_gate_input);

    // 200 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // tally counter zero events as they pulse
    always @(posedge aclk) begin
        ovf_seen += int'(overflow_evt_q[0] === 1'b1);
        unf_seen += int'(underflow_evt_q[0] === 1'b1);
    end

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    // one register write, valids held until taken
    task automatic wr(input int c, input logic [2:0] r, input logic [31:0] d,
        input logic [1:0] er = scg_pkg::RESP_OKAY);
        s_axi_awaddr <= {2'(c), r, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // each channel is released at the edge its own ready is seen
        fork
            begin
                do @(posedge aclk); while (s_axi_awready !== 1'b1);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (s_axi_wready !== 1'b1);
                s_axi_wvalid <= 1'b0;
            end
        join
        // late bready makes the slave hold its response
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge aclk);
    endtask

    // one register read into rd_q
    task automatic rd(input int c, input logic [2:0] r,
        input logic [1:0] er = scg_pkg::RESP_OKAY);
        s_axi_araddr <= {2'(c), r, 2'b00};
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        // late rready makes the slave hold its data
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd_q = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge aclk);
    endtask

    // read and compare the masked word
    task automatic rc(input int c, input logic [2:0] r, input logic [31:0] e,
        input logic [31:0] m = 32'hffff_ffff);
        rd(c, r);
        chk(rd_q & m, e);
    endtask

    // verdict and end of run
    task automatic test_done;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        aresetn = 1'b0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // test 1: reset values, unmapped places, read-only value
        rc(0, scg_pkg::REG_CTRL, 32'h0);
        rc(0, scg_pkg::REG_END, scg_pkg::LIM_MAX);
        rc(0, scg_pkg::REG_STATUS, 32'h0, 32'h3);
        rd(0, 3'h5, scg_pkg::RESP_SLVERR);
        chk(rd_q, 32'h0);
        wr(1, 3'h7, 32'h0, scg_pkg::RESP_SLVERR);
        wr(0, scg_pkg::REG_VALUE, 32'h1234_5678);
        rc(0, scg_pkg::REG_VALUE, 32'h0);
        $display("test 1 done");
        // test 2: continuous counting and flags on counter zero
        wr(0, scg_pkg::REG_LOAD, 32'h7fff_fffe);
        rc(0, scg_pkg::REG_VALUE, 32'h7fff_fffe);
        src.send(0, 1'b1, 1);
        rc(0, scg_pkg::REG_VALUE, 32'h7fff_fffe);
        wr(0, scg_pkg::REG_CTRL, 32'h190);
        src.send(0, 1'b1, 2);
        rc(0, scg_pkg::REG_VALUE, scg_pkg::LIM_MIN);
        rc(0, scg_pkg::REG_STATUS, 32'h1, 32'h3);
        src.send(0, 1'b0, 1);
        rc(0, scg_pkg::REG_VALUE, scg_pkg::LIM_MAX);
        rc(0, scg_pkg::REG_STATUS, 32'h3, 32'h3);
        chk(32'(ovf_seen + 2 * unf_seen), 32'h3);
        wr(0, scg_pkg::REG_STATUS, 32'h3);
        rc(0, scg_pkg::REG_STATUS, 32'h0, 32'h3);
        $display("test 2 done");
        // test 3: single shot without direction, both gate functions
        wr(1, scg_pkg::REG_LOAD, 32'h7fff_fffe);
        wr(1, scg_pkg::REG_CTRL, 32'h11);
        src.send(1, 1'b1, 4);
        rc(1, scg_pkg::REG_VALUE, scg_pkg::LIM_MIN);
        rc(1, scg_pkg::REG_STATUS, 32'h8, 32'h8);
        wr(1, scg_pkg::REG_CTRL, 32'h01);
        wr(1, scg_pkg::REG_CTRL, 32'h11);
        src.send(1, 1'b1, 1);
        rc(1, scg_pkg::REG_VALUE, 32'h8000_0001);
        src.send(1, 1'b0, 3);
        rc(1, scg_pkg::REG_VALUE, scg_pkg::LIM_MAX);
        wr(1, scg_pkg::REG_CTRL, 32'h21);
        wr(1, scg_pkg::REG_CTRL, 32'h31);
        rc(1, scg_pkg::REG_VALUE, 32'h7fff_fffe);
        $display("test 3 done");
        // test 4: directed and periodic cases on counter two
        for (int k = 0; k < 6; k++) begin
            wr(2, scg_pkg::REG_CTRL, 32'h0);
            wr(2, scg_pkg::REG_LOAD, tl[k]);
            wr(2, scg_pkg::REG_END, te[k]);
            wr(2, scg_pkg::REG_CTRL, {28'h0, tc[k]} | 32'h10);
            src.send(2, tu[k], tn[k]);
            rc(2, scg_pkg::REG_VALUE,
               tx[k]);
            rc(2, scg_pkg::REG_STATUS, {28'h0, tz[k], 3'h0},
               32'h8);
            if (tz[k]) begin
                wr(2, scg_pkg::REG_CTRL, {28'h0, tc[k]});
                wr(2, scg_pkg::REG_CTRL, {28'h0, tc[k]} | 32'h10);
                src.send(2, tu[k], 1);
                rc(2, scg_pkg::REG_VALUE, ty[k]);
            end
        end
        $display("test 4 done");
        // test 5: counter three internal gate
        wr(3, scg_pkg::REG_CTRL, 32'h40);
        wr(3, scg_pkg::REG_LOAD, 32'h0);
        wr(3, scg_pkg::REG_CTRL, 32'h50);
        src.send(3, 1'b1, 1);
        rc(3, scg_pkg::REG_VALUE, 32'h0);
        src.set_gate(1'b1);
        src.send(3, 1'b1, 1);
        rc(3, scg_pkg::REG_VALUE, 32'h1);
        src.set_gate(1'b0);
        wr(3, scg_pkg::REG_CTRL, 32'h10);
        src.send(3, 1'b1, 1);
        rc(3, scg_pkg::REG_VALUE, 32'h2);
        wr(3, scg_pkg::REG_CTRL, 32'h40);
        wr(3, scg_pkg::REG_LOAD, scg_pkg::LIM_MAX);
        src.set_gate(1'b1);
        wr(3, scg_pkg::REG_CTRL, 32'h51);
        src.send(3, 1'b1, 2);
        rc(3, scg_pkg::REG_VALUE, scg_pkg::LIM_MIN);
        src.set_gate(1'b0);
        src.set_gate(1'b1);
        src.send(3, 1'b1, 1);
        rc(3, scg_pkg::REG_VALUE, 32'h8000_0001);
        $display("test 5 done");
        test_done();
    end

    // cut a hang short well past the expected run length
    initial begin
        repeat (5000) @(posedge aclk);
        fails++;
        test_done();
    end
endmodule // signed_counter_modes_gate_bench
